// ===== include/usb_bridge_cfg.svh
/*
  Constants of the USB serial command bridge: request match values,
  packet layout, interface and status codes, and bit timing counts.
  Assumes a 20 MHz mclk shared with the USB device controller.
*/
`ifndef USB_BRIDGE_CFG_SVH
`define USB_BRIDGE_CFG_SVH

`define CFG_REQ_TYPE 8'h21
`define CFG_REQ_CODE 8'h09
`define CFG_REQ_INDEX 16'h0003
`define CFG_OP_WRITE_BIT 4
`define CFG_IF_GPIO 4'h8
`define CFG_IF_SPI_WIDE 4'h4
`define CFG_IF_I2C_FAST 4'h2
`define CFG_IF_I2C_STANDARD_SELECT 4'h1
`define CFG_IF_SPI_NARROW 4'h0
`define CFG_ST_DONE 8'h20
`define CFG_ST_BUS_FAIL 8'h40
`define CFG_ST_BAD_IF 8'h80
`define CFG_HDR_BYTES 4
`define CFG_MAX_DATA 60
`define CFG_EP0_MAX 64
`define CFG_RESP_MAX 42
`define CFG_FUNC_CLASS 8'hff
`define CFG_CLK_NS 50
`define CFG_I2C_STANDARD_SELECT_QUARTER_NS 2500
`define CFG_I2C_FAST_QUARTER_NS 625
`define CFG_SPI_QUARTER_NS 250
`define CFG_CYC(ns) (((ns) + `CFG_CLK_NS - 1) / `CFG_CLK_NS)

`endif

// ===== include/usb_bridge_pkg.sv
/*
  Types of the USB serial command bridge.
  Assumes usb_bridge_cfg.svh for all numeric constants.
*/
package usb_bridge_pkg;
  typedef logic [7:0] byte_t;
  typedef enum logic [2:0] {
    S_IDLE, S_RECV, S_EXEC, S_START, S_BITS, S_STOP, S_FIN, S_RESP
  } state_e;
endpackage : usb_bridge_pkg

// ===== hdl/usb_serial_command_bridge.sv
/*
  Command interpreter: takes a command packet from the control endpoint,
  runs it on I2C, SPI or GPIO and returns a status report.
  Assumes the USB controller shares mclk; pins are synchronised here.
*/
`include "usb_bridge_cfg.svh"
module usb_serial_command_bridge (
  input wire logic mclk,
  input wire logic rst,
  // Control endpoint setup stage
  input wire logic setupValid,
  input wire logic [7:0] setupReqType,
  input wire logic [7:0] setupRequest,
  input wire logic [15:0] setupIndex,
  // Control endpoint data stage
  input wire logic ep0Valid,
  input wire logic [7:0] ep0Data,
  input wire logic ep0Last,
  // Interrupt IN report stream
  input wire logic intReady,
  output logic intValid,
  output logic [7:0] intData,
  output logic intLast,
  // Function identity and status
  output logic [7:0] functionClass,
  output logic busy,
  output logic [7:0] lastStatus,
  // I2C open-drain pins
  output logic sclOut,
  output logic sclOe,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  // SPI pins
  output logic spiClk,
  output logic spiMosi,
  output logic spiCsN,
  input wire logic spiMiso,
  // GPIO pins
  input wire logic [6:0] gpioIn,
  output logic [6:0] gpioOut,
  output logic [6:0] gpioOe
);
  usb_bridge_pkg::state_e state;
  usb_bridge_pkg::byte_t pkt [`CFG_EP0_MAX];
  logic [6:0] rxCnt, idx, rIdx, lenEff, endIdx, respLen, nIdx;
  logic [7:0] sh, div, quarter, status;
  logic [3:0] bitCnt, code;
  logic [1:0] q, stage;
  logic rdPhase, busFailureFlag, tick, done, op, rx, lastRx, txNack;
  logic isGpio, isWide, isFast, i2cStandardSelect, isNarrow;
  logic i2cSel, spiSel, badIf, reportWriteRequest, drive, inBit;
  logic sdaS1, sdaS, misoS1, misoS;
  logic [6:0] gpioS1, gpioS;

  // Pin synchronisers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sdaS1 <= 1'b1;
      sdaS <= 1'b1;
      misoS1 <= 1'b0;
      misoS <= 1'b0;
      gpioS1 <= 7'h00;
      gpioS <= 7'h00;
    end else begin
      sdaS1 <= sdaIn;
      sdaS <= sdaS1;
      misoS1 <= spiMiso;
      misoS <= misoS1;
      gpioS1 <= gpioIn;
      gpioS <= gpioS1;
    end
  end

  // Command decode
  always_comb begin
    reportWriteRequest = setupValid && setupReqType == `CFG_REQ_TYPE
      && setupRequest == `CFG_REQ_CODE && setupIndex == `CFG_REQ_INDEX;
    op = pkt[0][`CFG_OP_WRITE_BIT];
    code = pkt[0][3:0];
    isGpio = code == `CFG_IF_GPIO;
    isWide = code == `CFG_IF_SPI_WIDE;
    isFast = code == `CFG_IF_I2C_FAST;
    i2cStandardSelect = code == `CFG_IF_I2C_STANDARD_SELECT;
    isNarrow = code == `CFG_IF_SPI_NARROW;
    i2cSel = isFast || i2cStandardSelect;
    spiSel = isWide || isNarrow;
    badIf = pkt[0][7:5] != 3'h0 || !(isGpio || i2cSel || spiSel);
    if (isGpio) begin
      lenEff = 7'd1;
    end else if (pkt[2] > 8'(`CFG_MAX_DATA)) begin
      lenEff = 7'(`CFG_MAX_DATA);
    end else begin
      lenEff = pkt[2][6:0];
    end
    endIdx = lenEff + 7'(`CFG_HDR_BYTES);
    respLen = (endIdx > 7'(`CFG_RESP_MAX)) ? 7'(`CFG_RESP_MAX)
      : endIdx;
    if (isFast) begin
      quarter = 8'(`CFG_CYC(`CFG_I2C_FAST_QUARTER_NS));
    end else if (i2cStandardSelect) begin
      quarter = 8'(`CFG_CYC(`CFG_I2C_STANDARD_SELECT_QUARTER_NS));
    end else begin
      quarter = 8'(`CFG_CYC(`CFG_SPI_QUARTER_NS));
    end
    tick = div == 8'h00;
    done = tick && q == 2'd3;
    rx = rdPhase && stage == 2'd2;
    lastRx = idx + 7'd1 == endIdx;
    txNack = !rx && sdaS;
    inBit = i2cSel ? sdaS : misoS;
    nIdx = (idx == 7'd1) ? (isWide ? 7'd3 : 7'd4) : idx + 7'd1;
    if (bitCnt == 4'd8) begin
      drive = rx && !lastRx;
    end else begin
      drive = !rx && !sh[7];
    end
    if (busFailureFlag) begin
      status = `CFG_ST_BUS_FAIL;
    end else if (badIf) begin
      status = `CFG_ST_BAD_IF;
    end else begin
      status = `CFG_ST_DONE;
    end
  end

  // Quarter-bit timing
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      div <= 8'h00;
      q <= 2'd0;
    end else if (state == usb_bridge_pkg::S_START
        || state == usb_bridge_pkg::S_BITS
        || state == usb_bridge_pkg::S_STOP) begin
      div <= tick ? quarter - 8'h01 : div - 8'h01;
      if (tick) begin
        q <= q + 2'd1;
      end
    end else begin
      div <= 8'h00;
      q <= 2'd0;
    end
  end

  // Sequencer
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state <= usb_bridge_pkg::S_IDLE;
      rxCnt <= 7'd0;
      idx <= 7'd0;
      sh <= 8'h00;
      bitCnt <= 4'd0;
      stage <= 2'd0;
      rdPhase <= 1'b0;
      busFailureFlag <= 1'b0;
    end else begin
      case (state)
        usb_bridge_pkg::S_IDLE: begin
          busFailureFlag <= 1'b0;
          rxCnt <= 7'd0;
          if (reportWriteRequest) begin
            state <= usb_bridge_pkg::S_RECV;
          end
        end
        usb_bridge_pkg::S_RECV: begin
          if (ep0Valid) begin
            if (rxCnt < 7'(`CFG_EP0_MAX)) begin
              rxCnt <= rxCnt + 7'd1;
            end
            if (ep0Last) begin
              state <= usb_bridge_pkg::S_EXEC;
            end
          end
        end
        usb_bridge_pkg::S_EXEC: begin
          stage <= 2'd0;
          rdPhase <= 1'b0;
          bitCnt <= 4'd0;
          if (badIf || isGpio) begin
            state <= usb_bridge_pkg::S_FIN;
          end else if (i2cSel) begin
            idx <= 7'd4;
            state <= usb_bridge_pkg::S_START;
          end else begin
            idx <= 7'd1;
            sh <= pkt[1];
            state <= usb_bridge_pkg::S_BITS;
          end
        end
        usb_bridge_pkg::S_START: begin
          if (done) begin
            sh <= {pkt[1][7:1], rdPhase};
            bitCnt <= 4'd0;
            state <= usb_bridge_pkg::S_BITS;
          end
        end
        usb_bridge_pkg::S_BITS: begin
          if (done && bitCnt < 4'd8) begin
            sh <= {sh[6:0], inBit};
          end
          if (done && spiSel && bitCnt == 4'd7) begin
            bitCnt <= 4'd0;
            idx <= nIdx;
            sh <= op ? pkt[nIdx[5:0]] : 8'h00;
            if (nIdx >= endIdx) begin
              state <= usb_bridge_pkg::S_FIN;
            end
          end else if (done && i2cSel && bitCnt == 4'd8) begin
            bitCnt <= 4'd0;
            if (txNack) begin
              busFailureFlag <= 1'b1;
              state <= usb_bridge_pkg::S_STOP;
            end else if (stage == 2'd0 && rdPhase) begin
              stage <= 2'd2;
              if (lenEff == 7'd0) begin
                state <= usb_bridge_pkg::S_STOP;
              end
            end else if (stage == 2'd0) begin
              stage <= 2'd1;
              sh <= pkt[3];
            end else if (stage == 2'd1 && !op) begin
              rdPhase <= 1'b1;
              stage <= 2'd0;
              state <= usb_bridge_pkg::S_START;
            end else if (stage == 2'd1) begin
              stage <= 2'd2;
              sh <= pkt[4];
              if (lenEff == 7'd0) begin
                state <= usb_bridge_pkg::S_STOP;
              end
            end else begin
              idx <= idx + 7'd1;
              sh <= pkt[nIdx[5:0]];
              if (lastRx) begin
                state <= usb_bridge_pkg::S_STOP;
              end
            end
          end else if (done) begin
            bitCnt <= bitCnt + 4'd1;
          end
        end
        usb_bridge_pkg::S_STOP: begin
          if (done) begin
            state <= usb_bridge_pkg::S_FIN;
          end
        end
        usb_bridge_pkg::S_FIN: begin
          state <= usb_bridge_pkg::S_RESP;
        end
        usb_bridge_pkg::S_RESP: begin
          if (rIdx >= respLen && (!intValid || intReady)) begin
            state <= usb_bridge_pkg::S_IDLE;
          end
        end
        default: begin
          state <= usb_bridge_pkg::S_IDLE;
        end
      endcase
    end
  end

  // Packet buffer
  always_ff @(posedge mclk) begin
    if (state == usb_bridge_pkg::S_RECV && ep0Valid
        && rxCnt < 7'(`CFG_EP0_MAX)) begin
      pkt[rxCnt[5:0]] <= ep0Data;
    end else if (state == usb_bridge_pkg::S_EXEC && isGpio && !op
        && !badIf) begin
      pkt[4] <= {1'b0, gpioS};
    end else if (state == usb_bridge_pkg::S_BITS && done && spiSel
        && bitCnt == 4'd7 && (idx < 7'd4 || !op)) begin
      pkt[idx[5:0]] <= {sh[6:0], misoS};
    end else if (state == usb_bridge_pkg::S_BITS && done && i2cSel
        && bitCnt == 4'd8 && rx) begin
      pkt[idx[5:0]] <= sh;
    end else if (state == usb_bridge_pkg::S_FIN) begin
      pkt[0] <= pkt[0] | status;
    end
  end

  // Serial pins
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sclOut <= 1'b0;
      sdaOut <= 1'b0;
      sclOe <= 1'b0;
      sdaOe <= 1'b0;
      spiClk <= 1'b0;
      spiMosi <= 1'b0;
      spiCsN <= 1'b1;
    end else begin
      sclOut <= 1'b0;
      sdaOut <= 1'b0;
      spiClk <= state == usb_bridge_pkg::S_BITS && spiSel && q[1];
      spiMosi <= sh[7];
      spiCsN <= !(state == usb_bridge_pkg::S_BITS && spiSel);
      case (state)
        usb_bridge_pkg::S_START: begin
          sclOe <= q == 2'd0 && rdPhase;
          sdaOe <= q[1];
        end
        usb_bridge_pkg::S_BITS: begin
          sclOe <= i2cSel && !q[1];
          sdaOe <= i2cSel && ((q == 2'd0) ? sdaOe : drive);
        end
        usb_bridge_pkg::S_STOP: begin
          sclOe <= !q[1];
          // Data line goes low once the clock is low and rises while it is high
          sdaOe <= (q == 2'd0) ? sdaOe : q != 2'd3;
        end
        default: begin
          sclOe <= 1'b0;
          sdaOe <= 1'b0;
        end
      endcase
    end
  end

  // GPIO lines
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      gpioOut <= 7'h00;
      gpioOe <= 7'h00;
    end else if (state == usb_bridge_pkg::S_EXEC && isGpio && op
        && !badIf) begin
      gpioOut <= pkt[4][6:0];
      gpioOe <= 7'h7f;
    end
  end

  // Interrupt report output
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      intValid <= 1'b0;
      intData <= 8'h00;
      intLast <= 1'b0;
      rIdx <= 7'd0;
    end else if (state != usb_bridge_pkg::S_RESP) begin
      intValid <= 1'b0;
      intLast <= 1'b0;
      rIdx <= 7'd0;
    end else if (!intValid || intReady) begin
      if (rIdx < respLen) begin
        intValid <= 1'b1;
        intData <= pkt[rIdx[5:0]];
        intLast <= rIdx + 7'd1 == respLen;
        rIdx <= rIdx + 7'd1;
      end else begin
        intValid <= 1'b0;
        intLast <= 1'b0;
      end
    end
  end

  // Identity and status
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      functionClass <= 8'h00;
      busy <= 1'b0;
      lastStatus <= 8'h00;
    end else begin
      functionClass <= `CFG_FUNC_CLASS;
      busy <= state != usb_bridge_pkg::S_IDLE
        && state != usb_bridge_pkg::S_RECV;
      if (state == usb_bridge_pkg::S_FIN) begin
        lastStatus <= pkt[0] | status;
      end
    end
  end
endmodule : usb_serial_command_bridge

// ===== verification/usb_bridge_props.sv
/* Checker for the command bridge report stream and serial pins.
   Assumes one clock domain and the asynchronous active-high reset. */
module usb_bridge_props (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Report stream
  input wire logic intReady,
  input wire logic intValid,
  input wire logic [7:0] intData,
  input wire logic intLast,
  // Status
  input wire logic [7:0] functionClass,
  input wire logic busy,
  input wire logic [7:0] lastStatus,
  // Serial pins
  input wire logic sclOut,
  input wire logic sclOe,
  input wire logic sdaOut,
  input wire logic sdaOe,
  input wire logic spiClk,
  input wire logic spiMosi,
  input wire logic spiCsN
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  logic firstByte;
  logic [5:0] byteCnt;
  // Position inside the current report
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      firstByte <= 1'b1;
      byteCnt <= 6'h00;
    end else if (intValid && intReady) begin
      firstByte <= intLast;
      byteCnt <= intLast ? 6'h00 : byteCnt + 6'h01;
    end
  end
  chk_class_vendor: assert property (
    !$past(rst) |-> functionClass == 8'hff)
    else $error("function class not vendor specific");
  chk_status_flags: assert property (intValid && firstByte |->
    $onehot(intData[7:5]) && intData == lastStatus)
    else $error("report status byte wrong");
  chk_resp_len: assert property (
    intValid && !intLast |-> byteCnt < 6'h29)
    else $error("report longer than 42 bytes");
  chk_report_hold: assert property (intValid && !intReady |=>
    intValid && $stable(intData) && $stable(intLast))
    else $error("report byte not held");
  chk_report_busy: assert property (intValid |-> busy)
    else $error("report outside busy");
  chk_spi_idle: assert property (!busy |-> spiCsN && !spiClk)
    else $error("spi active while idle");
  chk_i2c_idle: assert property (
    !busy |-> !sclOe && !sdaOe && !sclOut && !sdaOut)
    else $error("i2c active while idle");
  chk_clk_frame: assert property (spiClk |-> !spiCsN)
    else $error("spi clock outside frame");
  chk_mosi_edge: assert property ($changed(spiMosi) |-> !spiClk)
    else $error("mosi changed while clock high");
endmodule : usb_bridge_props

bind usb_serial_command_bridge usb_bridge_props chk_u (.mclk, .rst,
  .intReady, .intValid, .intData, .intLast, .functionClass, .busy,
  .lastStatus, .sclOut, .sclOe, .sdaOut, .sdaOe, .spiClk, .spiMosi,
  .spiCsN);

// ===== verification/serial_target_model.sv
/* Serial targets: an I2C device that acks unless nack is set and returns a fixed byte,
   and an SPI device returning a fixed byte. SDA has a pull-up. */
module serial_target_model (
  // I2C lines
  input wire logic scl,
  input wire logic sda,
  input wire logic nack,
  output logic sdaPull,
  // SPI lines
  input wire logic spiClk,
  input wire logic spiCsN,
  output logic miso
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] RdByte = 8'h5a;
  localparam logic [7:0] SpiByte = 8'hc3;
  int cnt;
  logic first, rd;
  logic [7:0] sh;
  initial begin
    sdaPull = 0;
    miso = 0;
    cnt = 0;
    first = 0;
    rd = 0;
    sh = SpiByte;
  end
  // Start condition rearms the byte counter
  always @(negedge sda) if (scl) begin
    cnt = 0;
    first = 1;
    rd = 0;
  end
  always @(posedge scl) begin
    cnt = cnt + 1;
    if (first && cnt == 8) rd = sda;
    if (rd && !first && cnt == 9 && sda) rd = 0;
  end
  // Ack, then read bits, changed while clock low
  always @(negedge scl) begin
    if (cnt == 9) begin
      cnt = 0;
      first = 0;
    end
    if (cnt == 8 && (first || !rd)) sdaPull <= !nack;
    else if (rd && !first && cnt < 8) sdaPull <= !RdByte[7-cnt];
    else sdaPull <= 0;
  end
  always @(negedge spiCsN) begin
    sh = SpiByte;
    miso <= SpiByte[7];
  end
  always @(negedge spiClk) if (!spiCsN) begin
    sh = {sh[6:0], sh[7]};
    miso <= sh[7];
  end
  always @(posedge spiCsN) miso <= !miso;
endmodule : serial_target_model

// ===== verification/usb_serial_command_bridge_tb.sv
/* Bench for the command bridge: command table, then refusal and reset.
   Assumes the checker bind and the serial target model. */
module usb_serial_command_bridge_tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {
    logic [47:0] cmd;
    int cl;
    logic [47:0] rsp;
    int rl;
    logic nack;
  } row_s;
  logic mclk, rst, setupValid, ep0Valid, ep0Last, intReady, intValid;
  logic [7:0] setupReqType, setupRequest, ep0Data, intData;
  logic [7:0] functionClass, lastStatus;
  logic [15:0] setupIndex;
  logic intLast, busy, sclOut, sclOe, sdaOut, sdaOe, spiClk, spiMosi;
  logic spiCsN, miso, sdaPull, nack;
  logic [6:0] gpioIn, gpioOut, gpioOe;
  wire logic scl = !sclOe;
  wire logic sda = !(sdaOe || sdaPull);
  int n_errors, cmp_count;
  row_s rows [11];
  assign gpioIn = (gpioOut & gpioOe) | (~gpioOe & 7'h2a);
  usb_serial_command_bridge dut_u (.mclk, .rst, .setupValid, .setupReqType,
    .setupRequest, .setupIndex, .ep0Valid, .ep0Data, .ep0Last, .intReady,
    .intValid, .intData, .intLast, .functionClass, .busy, .lastStatus,
    .sclOut, .sclOe, .sdaIn(sda), .sdaOut, .sdaOe, .spiClk, .spiMosi,
    .spiCsN, .spiMiso(miso), .gpioIn, .gpioOut, .gpioOe);
  serial_target_model tgt_u (.scl, .sda, .nack, .sdaPull, .spiClk, .spiCsN,
    .miso);
  initial begin
    mclk = 0;
    forever #25 mclk = ~mclk;
  end
  task automatic chk(input string what, input logic [7:0] seen,
      input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic send(input logic [7:0] t, input logic [47:0] c, input int cl);
    @(negedge mclk);
    setupValid = 1;
    setupReqType = t;
    setupRequest = 8'h09;
    setupIndex = 16'h0003;
    @(negedge mclk);
    setupValid = 0;
    for (int i = 0; i < cl; i++) begin
      @(negedge mclk);
      ep0Valid = 1;
      ep0Data = c[8*(cl-1-i) +: 8];
      ep0Last = (i == cl - 1);
    end
    @(negedge mclk);
    ep0Valid = 0;
    ep0Last = 0;
  endtask : send
  // Takes a report while stalling every other cycle
  task automatic drain(input logic [47:0] e, input int rl);
    int i;
    int w;
    i = 0;
    w = 0;
    while (i < rl && w < 40000) begin
      @(negedge mclk);
      w++;
      intReady = ~intReady;
      if (intValid === 1'b1 && intReady) begin
        chk("reportByte", intData, e[8*(rl-1-i) +: 8]);
        chk("reportLast", {7'h00, intLast}, {7'h00, i == rl - 1});
        i++;
      end
    end
    if (i < rl) chk("reportCount", i[7:0], rl[7:0]);
    @(negedge mclk);
    intReady = 0;
  endtask : drain
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (60000) @(posedge mclk);
    n_errors++;
    tally_and_finish;
  end
  initial begin
    {rst, setupValid, ep0Valid, ep0Last, intReady, nack} = 6'h21;
    {setupReqType, setupRequest, setupIndex, ep0Data} = 40'h00;
    n_errors = 0;
    cmp_count = 0;
    // Host keeps data within 32 bytes per command
    rows = '{'{48'h11a00205aa55, 6, 48'h31a00205aa55, 6, 0},
      '{48'h12a00205aa55, 6, 48'h32a00205aa55, 6, 0},
      '{48'h10a00205aa55, 6, 48'h30c30205aa55, 6, 0},
      '{48'h141002e0aa55, 6, 48'h34c302c3aa55, 6, 0},
      '{48'h00a00205, 4, 48'h20c30205c3c3, 6, 0},
      '{48'h02a00205, 4, 48'h22a002055a5a, 6, 0},
      '{48'h01a00205, 4, 48'h21a002055a5a, 6, 0},
      '{48'h11a00205aa55, 6, 48'h51a00205aa55, 6, 1},
      '{48'h13a00205aa55, 6, 48'h93a00205aa55, 6, 0},
      '{48'h1800010040, 5, 48'h3800010040, 5, 0},
      '{48'h08000100, 4, 48'h2800010040, 5, 0}};
    repeat (16) @(negedge mclk);
    chk("resetOuts",
      {intValid, busy, spiCsN, sclOe, sdaOe, |gpioOe, 2'h0}, 8'h20);
    chk("resetClass", functionClass, 8'h00);
    rst = 0;
    @(negedge mclk);
    chk("class", functionClass, 8'hff);
    foreach (rows[i]) begin
      nack = rows[i].nack;
      send(8'h21, rows[i].cmd, rows[i].cl);
      drain(rows[i].rsp, rows[i].rl);
      chk("lastStatus", lastStatus,
        rows[i].rsp[8*rows[i].rl-8 +: 8]);
    end
    chk("gpioOut", {1'b0, gpioOut}, 8'h40);
    chk("gpioOe", {1'b0, gpioOe}, 8'h7f);
    send(8'h22, 48'h1800010001, 5);
    repeat (200) @(negedge mclk);
    chk("refusedValid", {7'h00, intValid}, 8'h00);
    chk("refusedGpio", {1'b0, gpioOut}, 8'h40);
    // Reset in the middle of an I2C write
    send(8'h21, 48'h11a00205aa55, 6);
    repeat (400) @(negedge mclk);
    chk("midBusy", {7'h00, busy}, 8'h01);
    rst = 1;
    repeat (2) @(negedge mclk);
    chk("midReset",
      {intValid, busy, spiCsN, sclOe, sdaOe, |gpioOe, 2'h0}, 8'h20);
    rst = 0;
    @(negedge mclk);
    send(8'h21, 48'h08000100, 4);
    drain(48'h280001002a, 5);
    tally_and_finish;
  end
endmodule : usb_serial_command_bridge_tb
